// file: hw/adcwd_params.svh
`ifndef ADCWD_PARAMS_SVH
`define ADCWD_PARAMS_SVH

// ==========================================================================
// widths
// ==========================================================================
`define ADCWD_WORD_W            16
`define ADCWD_BYTE_W            8
`define ADCWD_ADDR_W            8

// ==========================================================================
// register offsets
// ==========================================================================
`define ADCWD_OFF_TRACK         8'hBA
`define ADCWD_OFF_RES_LO        8'hBD
`define ADCWD_OFF_RES_HI        8'hBE
`define ADCWD_OFF_GT_LO         8'hC3
`define ADCWD_OFF_GT_HI         8'hC4
`define ADCWD_OFF_LT_LO         8'hC5
`define ADCWD_OFF_LT_HI         8'hC6
`define ADCWD_OFF_CTRL          8'hE8
`define ADCWD_OFF_STAT          8'hF0
`define ADCWD_OFF_MASK          8'hF1

// ==========================================================================
// control register field positions
// ==========================================================================
`define ADCWD_CTRL_EN_BIT       7
`define ADCWD_CTRL_BURST_BIT    6
`define ADCWD_CTRL_DONE_BIT     5
`define ADCWD_CTRL_BUSY_BIT     4
`define ADCWD_CTRL_WINT_BIT     3
`define ADCWD_CTRL_LJST_BIT     2
`define ADCWD_CTRL_CM_LSB       0

// ==========================================================================
// status and mask field positions
// ==========================================================================
`define ADCWD_STAT_DONE_BIT     0
`define ADCWD_STAT_WIN_BIT      1

// ==========================================================================
// reset values
// ==========================================================================
`define ADCWD_RST_TRACK         8'hFF
`define ADCWD_RST_CTRL          8'h00
`define ADCWD_RST_GT            16'hFFFF
`define ADCWD_RST_LT            16'h0000
`define ADCWD_RST_RES           16'h0000
`define ADCWD_RST_STAT          8'h00
`define ADCWD_RST_MASK          8'h00

`endif

// file: hw/adcwd_pkg.sv
package adcwd_pkg;

    // ======================================================================
    // conversion start source selected in the control register
    // ======================================================================
    typedef enum logic [1:0] {
        ADCWD_START_SW,
        ADCWD_START_SRC1,
        ADCWD_START_SRC2,
        ADCWD_START_SRC3
    } adcwd_start_t;

    typedef logic [15:0] adcwd_word_t;

endpackage : adcwd_pkg

// file: hw/adcwd_cmp_if.sv
`timescale 1ns/1ps
// ==========================================================================
// window comparator hookup
// ==========================================================================
interface adcwd_cmp_if #(
    parameter int W = 16
);
    logic [W-1:0] result;
    logic [W-1:0] gt_lim;
    logic [W-1:0] lt_lim;
    logic         hit;

    modport ctl (output result, output gt_lim, output lt_lim, input  hit);
    modport cmp (input  result, input  gt_lim, input  lt_lim, output hit);
endinterface : adcwd_cmp_if

// file: hw/adcwd_window_cmp.sv
`timescale 1ns/1ps
// ==========================================================================
// unsigned window compare
// ==========================================================================
module adcwd_window_cmp #(
    parameter int W = 16
) (
    // limits and result in, hit out
    adcwd_cmp_if.cmp port_c
);
    logic above_gt;
    logic below_lt;

    // plain unsigned compares: single-ended words never go negative
    always_comb begin
        above_gt   = port_c.result > port_c.gt_lim;
        below_lt   = port_c.result < port_c.lt_lim;
        // limit ordering alone picks inside or outside window
        if (port_c.lt_lim > port_c.gt_lim) begin
            port_c.hit = above_gt && below_lt;
        end else begin
            port_c.hit = above_gt || below_lt;
        end
    end
endmodule : adcwd_window_cmp

// file: hw/adcwd_top.sv
`timescale 1ns/1ps
`include "adcwd_params.svh"
module adcwd_top
    import adcwd_pkg::*;
#(
    parameter int WORD_W = `ADCWD_WORD_W
) (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // register port
    input  wire logic [`ADCWD_ADDR_W-1:0]  addr,
    input  wire logic [`ADCWD_BYTE_W-1:0]  wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [`ADCWD_BYTE_W-1:0]  rd_data_ff,
    // converter side
    input  wire logic                      conv_done,
    input  wire logic [WORD_W-1:0]         conv_word,
    input  wire logic                      conv_busy,
    output logic                           start_conv_ff,
    // configuration towards the converter
    output logic                           converter_enable_ff,
    output logic                           burst_mode_enable_ff,
    output logic                           left_justify_select_ff,
    output adcwd_start_t                   start_mode_ff,
    output logic      [`ADCWD_BYTE_W-1:0]  tracking_mode_select_ff,
    // flags and interrupt
    output logic                           window_compare_flag_ff,
    output logic                           irq_ff
);

    // ======================================================================
    // declarations
    // ======================================================================
    logic [`ADCWD_BYTE_W-1:0]  upper_limit_high_byte_ff;
    logic [`ADCWD_BYTE_W-1:0]  upper_limit_low_byte_ff;
    logic [`ADCWD_BYTE_W-1:0]  lower_limit_high_byte_ff;
    logic [`ADCWD_BYTE_W-1:0]  lower_limit_low_byte_ff;
    logic [`ADCWD_BYTE_W-1:0]  nxt_upper_limit_high_byte;
    logic [`ADCWD_BYTE_W-1:0]  nxt_upper_limit_low_byte;
    logic [`ADCWD_BYTE_W-1:0]  nxt_lower_limit_high_byte;
    logic [`ADCWD_BYTE_W-1:0]  nxt_lower_limit_low_byte;

    logic [WORD_W-1:0]         result_ff;
    logic [WORD_W-1:0]         nxt_result;
    logic                      eval_ff;
    logic                      nxt_eval;

    logic                      nxt_converter_enable;
    logic                      nxt_burst_mode_enable;
    logic                      nxt_left_justify_select;
    adcwd_start_t              nxt_start_mode;
    logic                      conv_flag_ff;
    logic                      nxt_conv_flag;
    logic                      nxt_window_compare_flag;
    logic                      nxt_start_conv;
    logic [`ADCWD_BYTE_W-1:0]  nxt_tracking_mode_select;

    logic [`ADCWD_BYTE_W-1:0]  status_ff;
    logic [`ADCWD_BYTE_W-1:0]  nxt_status;
    logic [`ADCWD_BYTE_W-1:0]  mask_ff;
    logic [`ADCWD_BYTE_W-1:0]  nxt_mask;
    logic                      nxt_irq;
    logic [`ADCWD_BYTE_W-1:0]  nxt_rd_data;

    logic                      wr_ctrl;
    logic                      rd_stat;
    logic                      win_event;
    logic [`ADCWD_BYTE_W-1:0]  ctrl_view;

    // ======================================================================
    // window comparator
    // ======================================================================
    adcwd_cmp_if #(.W(WORD_W)) cmp_bus ();

    // limits are glued from bytes exactly as software wrote them, so a
    // left-justified result needs left-justified limits as well
    assign cmp_bus.result = result_ff;
    assign cmp_bus.gt_lim = WORD_W'({upper_limit_high_byte_ff,
                                     upper_limit_low_byte_ff});
    assign cmp_bus.lt_lim = WORD_W'({lower_limit_high_byte_ff,
                                     lower_limit_low_byte_ff});

    adcwd_window_cmp #(
        .W      (WORD_W)
    ) u_cmp (
        .port_c (cmp_bus.cmp)
    );

    // ======================================================================
    // shared decode
    // ======================================================================
    // one hit per completed conversion, judged on the stored word
    always_comb begin
        wr_ctrl   = wr_en && (addr == `ADCWD_OFF_CTRL);
        rd_stat   = rd_en && (addr == `ADCWD_OFF_STAT);
        win_event = eval_ff && cmp_bus.hit;
    end

    // ======================================================================
    // limit registers
    // ======================================================================
    // byte-wide writes; a half-updated limit is live until both halves land
    always_comb begin
        nxt_upper_limit_high_byte = upper_limit_high_byte_ff;
        nxt_upper_limit_low_byte  = upper_limit_low_byte_ff;
        nxt_lower_limit_high_byte = lower_limit_high_byte_ff;
        nxt_lower_limit_low_byte  = lower_limit_low_byte_ff;
        if (wr_en) begin
            if (addr == `ADCWD_OFF_GT_HI) begin
                nxt_upper_limit_high_byte = wr_data;
            end
            if (addr == `ADCWD_OFF_GT_LO) begin
                nxt_upper_limit_low_byte = wr_data;
            end
            if (addr == `ADCWD_OFF_LT_HI) begin
                nxt_lower_limit_high_byte = wr_data;
            end
            if (addr == `ADCWD_OFF_LT_LO) begin
                nxt_lower_limit_low_byte = wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            upper_limit_high_byte_ff <= `ADCWD_BYTE_W'(`ADCWD_RST_GT >> `ADCWD_BYTE_W);
            upper_limit_low_byte_ff  <= `ADCWD_BYTE_W'(`ADCWD_RST_GT);
            lower_limit_high_byte_ff <= `ADCWD_BYTE_W'(`ADCWD_RST_LT >> `ADCWD_BYTE_W);
            lower_limit_low_byte_ff  <= `ADCWD_BYTE_W'(`ADCWD_RST_LT);
        end else begin
            upper_limit_high_byte_ff <= nxt_upper_limit_high_byte;
            upper_limit_low_byte_ff  <= nxt_upper_limit_low_byte;
            lower_limit_high_byte_ff <= nxt_lower_limit_high_byte;
            lower_limit_low_byte_ff  <= nxt_lower_limit_low_byte;
        end
    end

    // ======================================================================
    // result register and evaluation strobe
    // ======================================================================
    // a finished conversion beats a software write in the same cycle
    always_comb begin
        nxt_result = result_ff;
        nxt_eval   = 1'b0;
        if (wr_en && (addr == `ADCWD_OFF_RES_HI)) begin
            nxt_result[WORD_W-1:`ADCWD_BYTE_W] = wr_data;
        end
        if (wr_en && (addr == `ADCWD_OFF_RES_LO)) begin
            nxt_result[`ADCWD_BYTE_W-1:0] = wr_data;
        end
        if (conv_done) begin
            nxt_result = conv_word;
            nxt_eval   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result_ff <= `ADCWD_RST_RES;
            eval_ff   <= 1'b0;
        end else begin
            result_ff <= nxt_result;
            eval_ff   <= nxt_eval;
        end
    end

    // ======================================================================
    // control and tracking registers
    // ======================================================================
    // hardware flags: writing 0 clears, writing 1 leaves them; a set in
    // the clearing cycle wins so no event is dropped
    always_comb begin
        nxt_converter_enable    = converter_enable_ff;
        nxt_burst_mode_enable   = burst_mode_enable_ff;
        nxt_left_justify_select = left_justify_select_ff;
        nxt_start_mode          = start_mode_ff;
        nxt_tracking_mode_select = tracking_mode_select_ff;
        nxt_conv_flag           = conv_flag_ff;
        nxt_window_compare_flag = window_compare_flag_ff;
        nxt_start_conv          = 1'b0;
        if (wr_ctrl) begin
            nxt_converter_enable    = wr_data[`ADCWD_CTRL_EN_BIT];
            nxt_burst_mode_enable   = wr_data[`ADCWD_CTRL_BURST_BIT];
            nxt_left_justify_select = wr_data[`ADCWD_CTRL_LJST_BIT];
            nxt_start_mode          = adcwd_start_t'(wr_data[`ADCWD_CTRL_CM_LSB +: 2]);
            if (!wr_data[`ADCWD_CTRL_DONE_BIT]) begin
                nxt_conv_flag = 1'b0;
            end
            if (!wr_data[`ADCWD_CTRL_WINT_BIT]) begin
                nxt_window_compare_flag = 1'b0;
            end
            // software start only when that source is selected
            if (wr_data[`ADCWD_CTRL_BUSY_BIT]
                && (adcwd_start_t'(wr_data[`ADCWD_CTRL_CM_LSB +: 2]) == ADCWD_START_SW)) begin
                nxt_start_conv = 1'b1;
            end
        end
        if (wr_en && (addr == `ADCWD_OFF_TRACK)) begin
            nxt_tracking_mode_select = wr_data;
        end
        if (conv_done) begin
            nxt_conv_flag = 1'b1;
        end
        if (win_event) begin
            nxt_window_compare_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            converter_enable_ff     <= 1'b0;
            burst_mode_enable_ff    <= 1'b0;
            left_justify_select_ff  <= 1'b0;
            start_mode_ff           <= ADCWD_START_SW;
            tracking_mode_select_ff <= `ADCWD_RST_TRACK;
            conv_flag_ff            <= 1'b0;
            window_compare_flag_ff  <= 1'b0;
            start_conv_ff           <= 1'b0;
        end else begin
            converter_enable_ff     <= nxt_converter_enable;
            burst_mode_enable_ff    <= nxt_burst_mode_enable;
            left_justify_select_ff  <= nxt_left_justify_select;
            start_mode_ff           <= nxt_start_mode;
            tracking_mode_select_ff <= nxt_tracking_mode_select;
            conv_flag_ff            <= nxt_conv_flag;
            window_compare_flag_ff  <= nxt_window_compare_flag;
            start_conv_ff           <= nxt_start_conv;
        end
    end

    // ======================================================================
    // interrupt status, mask and line
    // ======================================================================
    // reading status clears it, but a same-cycle event still lands
    always_comb begin
        nxt_mask   = mask_ff;
        nxt_status = status_ff;
        if (wr_en && (addr == `ADCWD_OFF_MASK)) begin
            nxt_mask = wr_data;
        end
        if (rd_stat) begin
            nxt_status = `ADCWD_RST_STAT;
        end
        if (conv_done) begin
            nxt_status[`ADCWD_STAT_DONE_BIT] = 1'b1;
        end
        if (win_event) begin
            nxt_status[`ADCWD_STAT_WIN_BIT] = 1'b1;
        end
        // computed from next values so the line tracks status exactly
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_ff <= `ADCWD_RST_STAT;
            mask_ff   <= `ADCWD_RST_MASK;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            irq_ff    <= nxt_irq;
        end
    end

    // ======================================================================
    // read port
    // ======================================================================
    // the window flag sits in the control byte so polling needs no irq
    always_comb begin
        ctrl_view = `ADCWD_RST_CTRL;
        ctrl_view[`ADCWD_CTRL_EN_BIT]        = converter_enable_ff;
        ctrl_view[`ADCWD_CTRL_BURST_BIT]     = burst_mode_enable_ff;
        ctrl_view[`ADCWD_CTRL_DONE_BIT]      = conv_flag_ff;
        ctrl_view[`ADCWD_CTRL_BUSY_BIT]      = conv_busy;
        ctrl_view[`ADCWD_CTRL_WINT_BIT]      = window_compare_flag_ff;
        ctrl_view[`ADCWD_CTRL_LJST_BIT]      = left_justify_select_ff;
        ctrl_view[`ADCWD_CTRL_CM_LSB +: 2]   = start_mode_ff;
    end

    // data valid only in the cycle after the strobe; unmapped reads zero
    always_comb begin
        nxt_rd_data = 8'h00;
        if (rd_en) begin
            case (addr)
                `ADCWD_OFF_TRACK:  nxt_rd_data = tracking_mode_select_ff;
                `ADCWD_OFF_RES_LO: nxt_rd_data = result_ff[`ADCWD_BYTE_W-1:0];
                `ADCWD_OFF_RES_HI: nxt_rd_data = result_ff[WORD_W-1:`ADCWD_BYTE_W];
                `ADCWD_OFF_GT_LO:  nxt_rd_data = upper_limit_low_byte_ff;
                `ADCWD_OFF_GT_HI:  nxt_rd_data = upper_limit_high_byte_ff;
                `ADCWD_OFF_LT_LO:  nxt_rd_data = lower_limit_low_byte_ff;
                `ADCWD_OFF_LT_HI:  nxt_rd_data = lower_limit_high_byte_ff;
                `ADCWD_OFF_CTRL:   nxt_rd_data = ctrl_view;
                `ADCWD_OFF_STAT:   nxt_rd_data = status_ff;
                `ADCWD_OFF_MASK:   nxt_rd_data = mask_ff;
                default:           nxt_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

endmodule : adcwd_top

// file: verification/adcwd_props.sv
`timescale 1ns/1ps
`include "adcwd_params.svh"
// ==========================================================================
// window detector checker
// ==========================================================================
module adcwd_props #(
    parameter int WORD_W = 16
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [7:0]        rd_data_ff,
    // converter side and flags
    input  wire logic              conv_done,
    input  wire logic [WORD_W-1:0] conv_word,
    input  wire logic              window_compare_flag_ff,
    input  wire logic              irq_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [WORD_W-1:0] gt_ff;
    logic [WORD_W-1:0] lt_ff;
    logic [WORD_W-1:0] nxt_gt;
    logic [WORD_W-1:0] nxt_lt;
    logic              hit;

    // unsigned compare; equal limits fall to the outside case
    function automatic logic hit_f(input logic [WORD_W-1:0] w, g, l);
        if (l > g) return (w > g) && (w < l);
        return (w < l) || (w > g);
    endfunction : hit_f

    // mirror of the limit bytes so the expected hit is known
    always_comb begin
        nxt_gt = gt_ff;
        nxt_lt = lt_ff;
        if (wr_en) begin
            case (addr)
                `ADCWD_OFF_GT_LO: nxt_gt[7:0]  = wr_data;
                `ADCWD_OFF_GT_HI: nxt_gt[15:8] = wr_data;
                `ADCWD_OFF_LT_LO: nxt_lt[7:0]  = wr_data;
                `ADCWD_OFF_LT_HI: nxt_lt[15:8] = wr_data;
                default: ;
            endcase
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gt_ff <= `ADCWD_RST_GT;
            lt_ff <= `ADCWD_RST_LT;
        end else begin
            gt_ff <= nxt_gt;
            lt_ff <= nxt_lt;
        end
    end
    assign hit = hit_f(conv_word, gt_ff, lt_ff);

    // limit writes in the same cycle are excluded: the mirror would lag
    sequence s_hit_conv;
        conv_done && !wr_en && hit;
    endsequence
    sequence s_miss_conv;
        conv_done && !wr_en && !hit && !window_compare_flag_ff
        ##1 !conv_done && !window_compare_flag_ff;
    endsequence

    rd_idle_zero_a: assert property (!rd_en |=> rd_data_ff == 8'h00)
        else $error("read data not zero outside a read");
    flag_readback_a: assert property (rd_en && addr == `ADCWD_OFF_CTRL
        |=> rd_data_ff[3] == $past(window_compare_flag_ff))
        else $error("control read does not show window flag");
    limit_readback_a: assert property (rd_en && addr == `ADCWD_OFF_GT_HI
        |=> rd_data_ff == gt_ff[15:8])
        else $error("upper limit high byte reads wrong");
    hit_sets_flag_a: assert property (s_hit_conv |-> ##2 window_compare_flag_ff)
        else $error("window flag not set two cycles after a hit");
    miss_stays_clear_a: assert property (s_miss_conv |=> !window_compare_flag_ff)
        else $error("window flag set by a miss");
    flag_sticky_a: assert property (window_compare_flag_ff
        && !(wr_en && addr == `ADCWD_OFF_CTRL && !wr_data[3]) |=> window_compare_flag_ff)
        else $error("window flag dropped without a clear");
    flag_clear_a: assert property (wr_en && addr == `ADCWD_OFF_CTRL && !wr_data[3]
        && !conv_done && !$past(conv_done) |=> !window_compare_flag_ff)
        else $error("window flag not cleared by write of zero");
    flag_cause_a: assert property ($rose(window_compare_flag_ff) |-> $past(conv_done, 2))
        else $error("window flag rose without a conversion");
    irq_cause_a: assert property ($rose(irq_ff)
        |-> $past(conv_done) || $past(conv_done, 2) || $past(wr_en))
        else $error("interrupt rose without a cause");
endmodule : adcwd_props

bind adcwd_top adcwd_props #(.WORD_W(WORD_W)) u_props (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_ff(rd_data_ff), .conv_done(conv_done), .conv_word(conv_word),
    .window_compare_flag_ff(window_compare_flag_ff), .irq_ff(irq_ff)
);

// file: verification/adc_window_detector_test.sv
`timescale 1ns/1ps
`include "adcwd_params.svh"
// ==========================================================================
// window detector bench
// ==========================================================================
module adc_window_detector_test;
    import adcwd_pkg::*;
    logic         sys_clk, rst, wr_en, rd_en, conv_done, conv_busy, start_conv_ff;
    logic         converter_enable_ff, burst_mode_enable_ff, left_justify_select_ff;
    logic         window_compare_flag_ff, irq_ff;
    logic [7:0]   addr, wr_data, rd_data_ff, tracking_mode_select_ff, rd_val;
    logic [15:0]  conv_word;
    adcwd_start_t start_mode_ff;
    int           bad_count, checks, i;
    // reset table and compare table: limits, word, expected hit
    logic [7:0]   r_addr [11] = '{8'hBA, 8'hBD, 8'hBE, 8'hC3, 8'hC4, 8'hC5, 8'hC6,
                                  8'hE8, 8'hF0, 8'hF1, 8'h00};
    logic [7:0]   r_exp  [11] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
                                  8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0]  c_gt [14] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0200,
        16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0100, 16'h1000, 16'h1000, 16'h0100};
    logic [15:0]  c_lt [14] = '{16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0100,
        16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h9000, 16'h2000, 16'h2000, 16'h0100};
    logic [15:0]  c_w  [14] = '{16'h0100, 16'h0101, 16'h01FF, 16'h0200, 16'h0000, 16'h00FF,
        16'h0100, 16'h0150, 16'h0200, 16'h0201, 16'h8000, 16'h1010, 16'h2000, 16'h0101};
    logic         c_hit [14] = '{0, 1, 1, 0, 0, 1, 0, 0, 0, 1, 1, 1, 0, 1};

    adcwd_top #(.WORD_W(16)) DUT (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data_ff(rd_data_ff), .conv_done(conv_done),
        .conv_word(conv_word), .conv_busy(conv_busy), .start_conv_ff(start_conv_ff),
        .converter_enable_ff(converter_enable_ff), .burst_mode_enable_ff(burst_mode_enable_ff),
        .left_justify_select_ff(left_justify_select_ff), .start_mode_ff(start_mode_ff),
        .tracking_mode_select_ff(tracking_mode_select_ff),
        .window_compare_flag_ff(window_compare_flag_ff), .irq_ff(irq_ff)
    );

    // 50 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ======================================================================
    // helpers
    // ======================================================================
    task automatic close_out();
        $display("counts: %0d compared, %0d wrong", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // strobes drop one edge later, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data_ff;
    endtask : rd
    // flag settles one edge after the done pulse is taken
    task automatic conv(input logic [15:0] w);
        @(posedge sys_clk);
        conv_done <= 1'b1;
        conv_word <= w;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : conv
    task automatic set_lim(input logic [15:0] g, input logic [15:0] l);
        wr(`ADCWD_OFF_GT_LO, g[7:0]);
        wr(`ADCWD_OFF_GT_HI, g[15:8]);
        wr(`ADCWD_OFF_LT_LO, l[7:0]);
        wr(`ADCWD_OFF_LT_HI, l[15:8]);
    endtask : set_lim
    task automatic wait_irq(input logic e);
        for (int n = 0; irq_ff !== e; n++) begin
            if (n == 8) begin
                bad_count++;
                close_out();
            end
            @(posedge sys_clk);
            #1;
        end
    endtask : wait_irq

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        {wr_en, rd_en, conv_done, conv_busy, addr, wr_data, conv_word} = '0;
        rst = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 11; i++) begin
            rd(r_addr[i], rd_val);
            check("reset read", rd_val, r_exp[i]);
        end
        check("tracking out", tracking_mode_select_ff, 16'h00FF);
        $display("test reset values done");
        for (i = 0; i < 14; i++) begin
            set_lim(c_gt[i], c_lt[i]);
            wr(`ADCWD_OFF_CTRL, 8'h00);
            rd(`ADCWD_OFF_STAT, rd_val);
            conv(c_w[i]);
            check("window flag", window_compare_flag_ff, c_hit[i]);
            rd(`ADCWD_OFF_CTRL, rd_val);
            check("control read", rd_val, 8'h20 | (c_hit[i] << 3));
        end
        $display("test compare table done");
        set_lim(16'h0100, 16'h0200);
        rd(`ADCWD_OFF_GT_HI, rd_val);
        check("upper high byte", rd_val, 8'h01);
        wr(`ADCWD_OFF_MASK, 8'h02);
        wr(`ADCWD_OFF_CTRL, 8'h00);
        rd(`ADCWD_OFF_STAT, rd_val);
        conv(16'h0180);
        wait_irq(1'b1);
        conv(16'h0100);
        check("flag after miss", window_compare_flag_ff, 1);
        rd(`ADCWD_OFF_STAT, rd_val);
        check("status", rd_val, 8'h03);
        check("irq after read", irq_ff, 0);
        rd(`ADCWD_OFF_STAT, rd_val);
        check("status cleared", rd_val, 8'h00);
        wr(`ADCWD_OFF_CTRL, 8'h08);
        check("flag write one", window_compare_flag_ff, 1);
        wr(`ADCWD_OFF_CTRL, 8'h00);
        check("flag write zero", window_compare_flag_ff, 0);
        wr(`ADCWD_OFF_MASK, 8'h00);
        conv(16'h01FF);
        check("masked irq", irq_ff, 0);
        check("polled flag", window_compare_flag_ff, 1);
        wr(`ADCWD_OFF_MASK, 8'h01);
        wait_irq(1'b1);
        rd(`ADCWD_OFF_STAT, rd_val);
        wait_irq(1'b0);
        $display("test interrupt done");
        wr(`ADCWD_OFF_TRACK, 8'h5A);
        check("tracking out", tracking_mode_select_ff, 16'h005A);
        wr(`ADCWD_OFF_CTRL, 8'hC7);
        check("config outs", {converter_enable_ff, burst_mode_enable_ff,
                              left_justify_select_ff, start_mode_ff}, 16'h001F);
        @(posedge sys_clk);
        conv_busy <= 1'b1;
        rd(`ADCWD_OFF_CTRL, rd_val);
        check("control busy", rd_val, 8'hD7);
        wr(`ADCWD_OFF_CTRL, 8'h10);
        check("start pulse", start_conv_ff, 1);
        @(posedge sys_clk);
        #1;
        check("start ends", start_conv_ff, 0);
        wr(8'h00, 8'hFF);
        rd(8'h00, rd_val);
        check("unmapped", rd_val, 8'h00);
        $display("test control done");
        close_out();
    end
endmodule : adc_window_detector_test
